// ---- rtl/pmc_ctrl.sv ----
// pmc_ctrl: global power mode controller, top level
// assumes firmware drives templates and mode requests synchronously
`timescale 1ns/1ps

// Function
// - four modes: active, alternate active, sleep, hibernate
// - each subsystem has an enable bit in active and alternate templates
// - sleep disables all except I2C, comparator and low-speed clocks
// - hibernate stops all clocks; only pin interrupt unit or device reset wakes it
// - alternate active uses own template; entered only by register write
// - sleep stops timers; wakes from six listed sources or device reset only
// - cleared enable gates the subsystem clock and drives bias disable
// - template changes apply on the next clock without a mode change, except the CPU bit while cpu_force_r is set
// - CPU may disable itself and is re-enabled at next wakeup
// - any wakeup returns mode to active and enables the CPU
// - controller starts in active mode after boot
// - wakeup from enabled interrupt or device reset returns to active
module pmc_ctrl (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // configuration templates
  input wire logic [7:0] act_template,
  input wire logic [7:0] alt_template,
  // mode request
  input wire logic mode_req_we,
  input wire logic [1:0] mode_req,
  // wake sources
  input wire logic [7:0] wake_src,
  input wire logic [7:0] wake_en,
  input wire logic device_reset,
  // status
  output logic [1:0] cur_mode,
  output logic cpu_run,
  output logic wake_pulse,
  // subsystem gating
  output logic [7:0] clk_gate_en,
  output logic [7:0] bias_dis,
  output logic clocks_off
);

  // ****************************************
  // mode state
  // ****************************************
  pmc_pkg::pmc_mode_e mode_r, mode_nxt;
  logic cpu_force_r, cpu_force_nxt;
  logic wake_r;

  function automatic logic [7:0] wake_mask(input pmc_pkg::pmc_mode_e m);
    case (m)
      pmc_pkg::PMC_SLEEP: wake_mask = pmc_pkg::SLEEP_WAKE_MASK;
      pmc_pkg::PMC_HIB: wake_mask = pmc_pkg::HIB_WAKE_MASK;
      default: wake_mask = 8'hFF;
    endcase
  endfunction : wake_mask

  wire [7:0] wake_ok = wake_src & wake_en & wake_mask(mode_r);
  wire wake_any = (|wake_ok) || device_reset;
  wire low_mode = (mode_r == pmc_pkg::PMC_SLEEP) ||
                  (mode_r == pmc_pkg::PMC_HIB);

  always_comb begin
    mode_nxt = mode_r;
    cpu_force_nxt = cpu_force_r;
    if (wake_any) begin
      mode_nxt = pmc_pkg::PMC_ACTIVE;
      cpu_force_nxt = 1'b1;
    end else if (mode_req_we) begin
      mode_nxt = pmc_pkg::pmc_mode_e'(mode_req);
      cpu_force_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      mode_r <= pmc_pkg::PMC_ACTIVE;
      cpu_force_r <= 1'b1;
      wake_r <= 1'b0;
    end else begin
      mode_r <= mode_nxt;
      cpu_force_r <= cpu_force_nxt;
      wake_r <= wake_any;
    end
  end

  // ****************************************
  // effective enables
  // ****************************************
  logic [7:0] tmpl;
  logic [7:0] eff;

  always_comb begin
    case (mode_r)
      pmc_pkg::PMC_ACTIVE: tmpl = act_template;
      pmc_pkg::PMC_ALT: tmpl = alt_template;
      pmc_pkg::PMC_SLEEP: tmpl = pmc_pkg::SLEEP_KEEP;
      pmc_pkg::PMC_HIB: tmpl = 8'h00;
      default: tmpl = 8'h00;
    endcase
    eff = tmpl;
    if (!low_mode && cpu_force_r) begin
      eff[pmc_pkg::SUB_CPU] = 1'b1;
    end
  end

  pmc_gate_if gif ();
  assign gif.enable = eff;
  assign gif.clocks_off = (mode_r == pmc_pkg::PMC_HIB);

  pmc_gate u_gate (
    .clk(clk),
    .resetn(resetn),
    .gif(gif)
  );

  assign cur_mode = mode_r;
  assign clk_gate_en = gif.clk_gate_en;
  assign bias_dis = gif.bias_dis;
  assign clocks_off = gif.clocks_off;
  assign wake_pulse = wake_r;
  assign cpu_run = clk_gate_en[pmc_pkg::SUB_CPU];

  // ****************************************
  // checks
  // ****************************************
  chk_boot_active: assert property (@(posedge clk)
    !resetn |=> mode_r == pmc_pkg::PMC_ACTIVE)
    else $error("mode not active after reset");
  chk_wake_active: assert property (@(posedge clk) disable iff (!resetn)
    wake_any |=> mode_r == pmc_pkg::PMC_ACTIVE)
    else $error("wakeup did not return to active");
  chk_wake_cpu: assert property (@(posedge clk) disable iff (!resetn)
    wake_any |=> ##1 clk_gate_en[pmc_pkg::SUB_CPU])
    else $error("cpu not enabled after wakeup");
  chk_sleep_gate: assert property (@(posedge clk) disable iff (!resetn)
    mode_r == pmc_pkg::PMC_SLEEP |=>
      (clk_gate_en & ~pmc_pkg::SLEEP_KEEP) == 8'h00)
    else $error("subsystem left running in sleep");
  chk_hib_off: assert property (@(posedge clk) disable iff (!resetn)
    mode_r == pmc_pkg::PMC_HIB && $past(mode_r) == pmc_pkg::PMC_HIB
      |-> clk_gate_en == 8'h00)
    else $error("clock running in hibernate");
  chk_hib_wake: assert property (@(posedge clk) disable iff (!resetn)
    mode_r == pmc_pkg::PMC_HIB && !device_reset &&
      (wake_src & wake_en & pmc_pkg::HIB_WAKE_MASK) == 8'h00
      |=> mode_r != pmc_pkg::PMC_ACTIVE)
    else $error("hibernate left by a non pin source");
  chk_sleep_src: assert property (@(posedge clk) disable iff (!resetn)
    mode_r == pmc_pkg::PMC_SLEEP && !device_reset && !mode_req_we &&
      (wake_src & wake_en & pmc_pkg::SLEEP_WAKE_MASK) == 8'h00
      |=> mode_r == pmc_pkg::PMC_SLEEP)
    else $error("sleep left by disallowed source");
  chk_req_mode: assert property (@(posedge clk) disable iff (!resetn)
    mode_req_we && !wake_any |=> cur_mode == $past(mode_req))
    else $error("mode request not applied");
  chk_alt_tmpl: assert property (@(posedge clk) disable iff (!resetn)
    mode_r == pmc_pkg::PMC_ALT && $stable(mode_r) && !cpu_force_r
      |=> clk_gate_en == $past(alt_template))
    else $error("alternate template not applied");
  chk_tmpl_live: assert property (@(posedge clk) disable iff (!resetn)
    mode_r == pmc_pkg::PMC_ACTIVE && !cpu_force_r
      |=> clk_gate_en == $past(act_template))
    else $error("active template change not applied");
  chk_reset_wake: assert property (@(posedge clk) disable iff (!resetn)
    device_reset |=> mode_r == pmc_pkg::PMC_ACTIVE)
    else $error("device reset did not return to active");

  // ****************************************
  // entry checks
  // ****************************************
  // low modes and alternate active are only reached by a write
  chk_alt_entry: assert property (@(posedge clk) disable iff (!resetn)
    mode_r != pmc_pkg::PMC_ALT && !mode_req_we
      |=> mode_r != pmc_pkg::PMC_ALT)
    else $error("alternate active entered without a write");

  chk_sleep_entry: assert property (@(posedge clk) disable iff (!resetn)
    mode_r != pmc_pkg::PMC_SLEEP && !mode_req_we
      |=> mode_r != pmc_pkg::PMC_SLEEP)
    else $error("sleep entered without a write");

  chk_hib_entry: assert property (@(posedge clk) disable iff (!resetn)
    mode_r != pmc_pkg::PMC_HIB && !mode_req_we
      |=> mode_r != pmc_pkg::PMC_HIB)
    else $error("hibernate entered without a write");

  chk_hib_flag: assert property (@(posedge clk) disable iff (!resetn)
    mode_req_we && mode_req == 2'b11 && !wake_any
      |=> clocks_off)
    else $error("clocks not stopped on hibernate entry");

  // ****************************************
  // wake checks
  // ****************************************
  chk_hib_pin: assert property (@(posedge clk) disable iff (!resetn)
    mode_r == pmc_pkg::PMC_HIB &&
      wake_src[pmc_pkg::WK_PIN] && wake_en[pmc_pkg::WK_PIN]
      |=> mode_r == pmc_pkg::PMC_ACTIVE)
    else $error("pin wake ignored in hibernate");

  chk_sleep_ok: assert property (@(posedge clk) disable iff (!resetn)
    mode_r == pmc_pkg::PMC_SLEEP &&
      (wake_src & wake_en & pmc_pkg::SLEEP_WAKE_MASK) != 8'h00
      |=> mode_r == pmc_pkg::PMC_ACTIVE)
    else $error("allowed wake ignored in sleep");

  chk_run_wake: assert property (@(posedge clk) disable iff (!resetn)
    !low_mode && (wake_src & wake_en) != 8'h00
      |=> mode_r == pmc_pkg::PMC_ACTIVE)
    else $error("interrupt wake ignored while running");

  chk_pulse_set: assert property (@(posedge clk) disable iff (!resetn)
    wake_any |=> wake_pulse)
    else $error("wake flag missing");

  chk_pulse_quiet: assert property (@(posedge clk) disable iff (!resetn)
    !wake_any |=> !wake_pulse)
    else $error("wake flag without a wake");

  chk_force_set: assert property (@(posedge clk) disable iff (!resetn)
    wake_any |=> cpu_force_r)
    else $error("cpu force not set by wake");

  chk_force_clear: assert property (@(posedge clk) disable iff (!resetn)
    mode_req_we && !wake_any |=> !cpu_force_r)
    else $error("cpu force kept after a write");

  // ****************************************
  // gating checks
  // ****************************************
  chk_cpu_keep: assert property (@(posedge clk) disable iff (!resetn)
    cpu_force_r && !low_mode
      |=> clk_gate_en[pmc_pkg::SUB_CPU])
    else $error("forced cpu left gated");

  chk_low_cpu: assert property (@(posedge clk) disable iff (!resetn)
    low_mode |=> !clk_gate_en[pmc_pkg::SUB_CPU])
    else $error("cpu clock running in a low mode");

  chk_sleep_keep: assert property (@(posedge clk) disable iff (!resetn)
    mode_r == pmc_pkg::PMC_SLEEP && $stable(mode_r)
      |=> clk_gate_en == pmc_pkg::SLEEP_KEEP)
    else $error("sleep keep set not applied");

  chk_gate_eff: assert property (@(posedge clk) disable iff (!resetn)
    !gif.clocks_off |=> clk_gate_en == $past(eff))
    else $error("clock gates lag the enables");

  chk_bias_eff: assert property (@(posedge clk) disable iff (!resetn)
    !gif.clocks_off |=> bias_dis == ~$past(eff))
    else $error("bias disable does not follow enables");

  chk_reset_gates: assert property (@(posedge clk)
    !resetn |=> clk_gate_en == pmc_pkg::ACT_TMPL_RST)
    else $error("gates not restored by reset");

  chk_reset_pulse: assert property (@(posedge clk)
    !resetn |=> !wake_pulse)
    else $error("wake flag set after reset");

  // ****************************************
  // hibernate residency
  // ****************************************
  // cycles spent in hibernate, saturating
  logic [3:0] hib_cnt_r, hib_cnt_nxt;

  assign hib_cnt_nxt = (mode_r != pmc_pkg::PMC_HIB) ? 4'h0 :
                       (hib_cnt_r == 4'hF) ? 4'hF : hib_cnt_r + 4'h1;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      hib_cnt_r <= 4'h0;
    end else begin
      hib_cnt_r <= hib_cnt_nxt;
    end
  end

  // after two cycles in hibernate every clock and bias must be off
  chk_hib_dark: assert property (@(posedge clk) disable iff (!resetn)
    hib_cnt_r >= 4'h2
      |-> clk_gate_en == 8'h00 && bias_dis == 8'hFF)
    else $error("subsystem powered in hibernate");


  cov_sleep_wake: cover property (@(posedge clk) disable iff (!resetn)
    mode_r == pmc_pkg::PMC_SLEEP ##1 mode_r == pmc_pkg::PMC_ACTIVE);
  cov_hib_wake: cover property (@(posedge clk) disable iff (!resetn)
    mode_r == pmc_pkg::PMC_HIB ##1 mode_r == pmc_pkg::PMC_ACTIVE);
  cov_alt_entry: cover property (@(posedge clk) disable iff (!resetn)
    mode_r == pmc_pkg::PMC_ACTIVE ##1 mode_r == pmc_pkg::PMC_ALT);
  cov_cpu_off: cover property (@(posedge clk) disable iff (!resetn)
    mode_r == pmc_pkg::PMC_ALT && !clk_gate_en[pmc_pkg::SUB_CPU]);
  cov_reset_hib: cover property (@(posedge clk) disable iff (!resetn)
    mode_r == pmc_pkg::PMC_HIB && device_reset);

endmodule : pmc_ctrl

// ---- rtl/pmc_gate.sv ----
// pmc_gate: registered clock gate enables and bias disables
// assumes enables arrive already resolved for the current mode
`timescale 1ns/1ps
module pmc_gate (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // enables in, gates out
  pmc_gate_if.gate gif
);
  logic [7:0] run_en;

  assign run_en = gif.clocks_off ? 8'h00 : gif.enable;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      gif.clk_gate_en <= pmc_pkg::ACT_TMPL_RST;
      gif.bias_dis <= ~pmc_pkg::ACT_TMPL_RST;
    end else begin
      gif.clk_gate_en <= run_en;
      gif.bias_dis <= ~run_en;
    end
  end

  chk_gate_follow: assert property (@(posedge clk) disable iff (!resetn)
    gif.clk_gate_en == ~gif.bias_dis)
    else $error("clock gate and bias disable disagree");
endmodule : pmc_gate

// ---- rtl/pmc_gate_if.sv ----
// pmc_gate_if: carries effective enables to the gating stage
// assumes one clock domain shared by both ends
`timescale 1ns/1ps
interface pmc_gate_if;
  logic [7:0] enable;
  logic clocks_off;
  logic [7:0] clk_gate_en;
  logic [7:0] bias_dis;
  modport ctrl (output enable, output clocks_off,
                input clk_gate_en, input bias_dis);
  modport gate (input enable, input clocks_off,
                output clk_gate_en, output bias_dis);
endinterface : pmc_gate_if

// ---- rtl/pmc_pkg.sv ----
// pmc_pkg: constants and types for the power mode controller
// assumes nothing beyond a SystemVerilog compiler
package pmc_pkg;

  // ****************************************
  // subsystem enable positions
  // ****************************************
  localparam int NSUB = 8;
  localparam int SUB_CPU = 0;
  localparam int SUB_FLASH = 1;
  localparam int SUB_I2C = 2;
  localparam int SUB_CMP = 3;
  localparam int SUB_LSOSC = 4;
  localparam int SUB_TIMER = 5;
  localparam int SUB_UDB = 6;
  localparam int SUB_ANALOG = 7;

  // subsystems that keep running through sleep
  localparam logic [7:0] SLEEP_KEEP = 8'h1C;
  localparam logic [7:0] ACT_TMPL_RST = 8'hFF;
  localparam logic [7:0] ALT_TMPL_RST = 8'hFF;

  // ****************************************
  // wake source positions
  // ****************************************
  localparam int NWAKE = 8;
  localparam int WK_CMP = 0;
  localparam int WK_PIN = 1;
  localparam int WK_I2C = 2;
  localparam int WK_RTC = 3;
  localparam int WK_TIMEWHEEL = 4;
  localparam int WK_LVD = 5;
  localparam int WK_OTHER = 6;
  localparam logic [7:0] SLEEP_WAKE_MASK = 8'h3F;
  localparam logic [7:0] HIB_WAKE_MASK = 8'h02;
  localparam logic [7:0] WAKE_EN_RST = 8'hFF;

  // ****************************************
  // modes
  // ****************************************
  typedef enum logic [1:0] {
    PMC_ACTIVE = 2'b00,
    PMC_ALT = 2'b01,
    PMC_SLEEP = 2'b10,
    PMC_HIB = 2'b11
  } pmc_mode_e;

endpackage : pmc_pkg

// ---- tb/pmc_ctrl_tb.sv ----
// pmc_ctrl_tb: self-checking bench for the power mode controller
// assumes pmc_ctrl timing: mode one edge after a request, gates one later
`timescale 1ns/1ps
module pmc_ctrl_tb;
  // ****************************************
  // signals and design
  // ****************************************
  logic clk, resetn, mode_req_we, device_reset;
  logic [7:0] act_template, alt_template, wake_src, wake_en;
  logic [1:0] mode_req, cur_mode;
  logic cpu_run, wake_pulse, clocks_off;
  logic [7:0] clk_gate_en, bias_dis;
  int failures, checks, cycles;

  pmc_ctrl i_pmc_ctrl (.clk(clk), .resetn(resetn),
    .act_template(act_template), .alt_template(alt_template),
    .mode_req_we(mode_req_we), .mode_req(mode_req),
    .wake_src(wake_src), .wake_en(wake_en), .device_reset(device_reset),
    .cur_mode(cur_mode), .cpu_run(cpu_run), .wake_pulse(wake_pulse),
    .clk_gate_en(clk_gate_en), .bias_dis(bias_dis),
    .clocks_off(clocks_off));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic stop_test;
    if (failures == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : stop_test

  task automatic req(input logic [1:0] m);
    mode_req = m;
    mode_req_we = 1'b1;
    tick(1);
    mode_req_we = 1'b0;
  endtask : req

  task automatic wake(input int b);
    wake_src[b] = 1'b1;
    tick(1);
    wake_src = 8'h00;
  endtask : wake

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset;
    chk({6'h00, cur_mode}, 8'h00);
    chk(clk_gate_en, 8'hFF);
    chk(bias_dis, 8'h00);
    chk({7'h00, clocks_off}, 8'h00);
    chk({7'h00, cpu_run}, 8'h01);
  endtask : t_reset

  task automatic t_templates;
    act_template = 8'h5A;
    req(2'b00);
    chk({6'h00, cur_mode}, 8'h00);
    tick(1);
    chk(clk_gate_en, 8'h5A);
    chk(bias_dis, 8'hA5);
    chk({7'h00, cpu_run}, 8'h00);
    act_template = 8'h3C;
    tick(2);
    chk(clk_gate_en, 8'h3C);
    chk(bias_dis, 8'hC3);
  endtask : t_templates

  task automatic t_alt;
    alt_template = 8'h40;
    req(2'b01);
    chk({6'h00, cur_mode}, 8'h01);
    tick(1);
    chk(clk_gate_en, 8'h40);
    wake(6);
    chk({6'h00, cur_mode}, 8'h00);
    chk({7'h00, wake_pulse}, 8'h01);
    tick(1);
    chk({7'h00, wake_pulse}, 8'h00);
    chk(clk_gate_en, 8'h3D);
    chk({7'h00, cpu_run}, 8'h01);
  endtask : t_alt

  task automatic t_sleep;
    act_template = 8'hFF;
    for (int b = 0; b < 6; b++) begin
      req(2'b10);
      chk({6'h00, cur_mode}, 8'h02);
      tick(1);
      chk(clk_gate_en, 8'h1C);
      chk(bias_dis, 8'hE3);
      wake_src[6] = 1'b1;
      tick(2);
      wake_src = 8'h00;
      chk({6'h00, cur_mode}, 8'h02);
      wake(b);
      chk({6'h00, cur_mode}, 8'h00);
      tick(1);
    end
    req(2'b10);
    wake_en = 8'hFE;
    wake(0);
    tick(1);
    chk({6'h00, cur_mode}, 8'h02);
    wake_en = 8'hFF;
    device_reset = 1'b1;
    tick(1);
    device_reset = 1'b0;
    chk({6'h00, cur_mode}, 8'h00);
  endtask : t_sleep

  task automatic t_hib;
    req(2'b11);
    chk({6'h00, cur_mode}, 8'h03);
    chk({7'h00, clocks_off}, 8'h01);
    tick(1);
    chk(clk_gate_en, 8'h00);
    wake(0);
    tick(1);
    chk({6'h00, cur_mode}, 8'h03);
    wake_src[1] = 1'b1;
    req(2'b11);
    wake_src = 8'h00;
    chk({6'h00, cur_mode}, 8'h00);
    chk({7'h00, clocks_off}, 8'h00);
  endtask : t_hib

  task automatic t_rst;
    req(2'b11);
    resetn = 1'b0;
    tick(2);
    resetn = 1'b1;
    chk({6'h00, cur_mode}, 8'h00);
    chk(clk_gate_en, 8'hFF);
    chk({7'h00, clocks_off}, 8'h00);
    chk({7'h00, wake_pulse}, 8'h00);
  endtask : t_rst

  // ****************************************
  // main sequence and timeout
  // ****************************************
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      failures++;
      stop_test();
    end
  end

  initial begin
    resetn = 1'b0;
    mode_req_we = 1'b0;
    mode_req = 2'b00;
    device_reset = 1'b0;
    act_template = 8'hFF;
    alt_template = 8'hFF;
    wake_src = 8'h00;
    wake_en = 8'hFF;
    tick(20);
    resetn = 1'b1;
    t_reset();
    t_templates();
    t_alt();
    t_sleep();
    t_hib();
    t_rst();
    stop_test();
  end
endmodule : pmc_ctrl_tb
